// [verilog/aor_pkg.sv]
// constants for the output configuration register slice
package aor_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_PREAMP_BIAS_LEVEL     = 7'h12;
  localparam logic [6:0] ADDR_OUTPUT_FORMAT_CONTROL = 7'h14;
  localparam logic [6:0] ADDR_OUTPUT_DRIVE_ADJUST   = 7'h15;
  localparam logic [6:0] ADDR_REFERENCE_SELECT      = 7'h18;
  localparam logic [6:0] ADDR_USER_PATTERN_ONE_LOW  = 7'h19;
  localparam logic [6:0] ADDR_USER_PATTERN_ONE_HIGH = 7'h1a;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PREAMP_BIAS_LEVEL      = 8'h09;
  localparam logic [7:0] RST_OUTPUT_FORMAT_CONTROL  = 8'h00;
  localparam logic [7:0] RST_OUTPUT_DRIVE_ADJUST    = 8'h0f;
  localparam logic [7:0] RST_REFERENCE_SELECT       = 8'h03;
  localparam logic [7:0] RST_USER_PATTERN           = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIAS_LSB          = 0;
  localparam int FMT_TWOS_BIT      = 0;
  localparam int FMT_INVERT_BIT    = 2;
  localparam int ADJ_DISABLE_BIT   = 7;
  localparam int ADJ_EDGE_LSB      = 2;
  localparam int ADJ_DRIVE_LSB     = 0;
  localparam int REF_EXTERNAL_BIT  = 6;
  localparam int REF_LEVEL_LSB     = 0;
  // bias register bit 3 reads as its reset value, not stored
  localparam logic [7:0] BIAS_FIXED_BITS = 8'h08;
  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int          FRAME_BITS  = 16;
  localparam logic [4:0]  CNT_HEADER  = 5'h08;
  localparam logic [4:0]  CNT_FRAME   = 5'h10;
  // ---------------------------------------------------------------
  // test pattern selections and fixed words
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    AOR_TM_OFF      = 4'b0000,
    AOR_TM_MID      = 4'b0001,
    AOR_TM_PFS      = 4'b0010,
    AOR_TM_NFS      = 4'b0011,
    AOR_TM_CHECKER  = 4'b0100,
    AOR_TM_PN_LONG  = 4'b0101,
    AOR_TM_PN_SHORT = 4'b0110,
    AOR_TM_WORD_TGL = 4'b0111,
    AOR_TM_USER     = 4'b1000,
    AOR_TM_BIT_TGL  = 4'b1001,
    AOR_TM_SYNC     = 4'b1010,
    AOR_TM_ONE_HIGH = 4'b1011,
    AOR_TM_MIXED    = 4'b1100
  } aor_test_mode_t;
  localparam logic [11:0] PAT_MID     = 12'h800;
  localparam logic [11:0] PAT_PFS     = 12'hfff;
  localparam logic [11:0] PAT_NFS     = 12'h000;
  localparam logic [11:0] PAT_CHECKER = 12'haaa;
  localparam logic [11:0] PAT_SYNC    = 12'h03f;
  localparam logic [11:0] PAT_MIXED   = 12'ha33;
endpackage

// [verilog/aor_output_config_regs.sv]
// output configuration registers, serial port slave and output data path
// ---------------------------------------------------------------
// Overview of operation
// - format register resets to zero; bit 0 picks twos complement globally, bit 2 inverts the addressed channel.
// - drive-adjust bit 7 low drives all twelve data outputs and high disables them.
// - drive-adjust holds a 2-bit edge rate field and a 2-bit drive field, both reset to ones for a value of 0x0f.
// - reference bit 6 picks internal (0) or external (1) reference, bits 1:0 set the internal level, reset 0x03.
// - in user test mode the output word is the upper 12 bits of the 16-bit pattern, with the low byte at the lower address.
// - while a test mode other than the two pn modes is active the test data replaces converted data on the outputs.
// ---------------------------------------------------------------
`timescale 1ns/1ps
module aor_output_config_regs #(
  parameter int NUM_CH = 5
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        spi_sclk,
  input  wire logic        spi_csb_n,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe_n,
  input  wire logic [2:0]  chan_sel,
  input  wire logic [3:0]  test_pattern_control,
  input  wire logic        adc_valid,
  input  wire logic [2:0]  adc_ch,
  input  wire logic [11:0] adc_data,
  output logic             data_valid,
  output logic [2:0]       data_ch,
  output logic [11:0]      data_out,
  output logic             data_oe_n,
  output logic [1:0]       preamp_bias,
  output logic [1:0]       edge_rate,
  output logic [1:0]       drive_strength,
  output logic             ref_external,
  output logic [1:0]       ref_level
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sclk_q;
  logic [1:0] csb_q;
  logic [1:0] sdi_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_q <= 3'h0;
      csb_q  <= 2'h3;
      sdi_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      csb_q  <= {csb_q[0], spi_csb_n};
      sdi_q  <= {sdi_q[0], spi_sdio_in};
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_active = ~csb_q[1];
  // ---------------------------------------------------------------
  // serial port and register state
  // ---------------------------------------------------------------
  logic [4:0]        bit_cnt,       next_bit_cnt;
  logic [15:0]       rx_shift,      next_rx_shift;
  logic [7:0]        tx_shift,      next_tx_shift;
  logic              sdo,           next_sdo;
  logic              sdo_oe_n,      next_sdo_oe_n;
  logic [1:0]        bias,          next_bias;
  logic              fmt_twos,      next_fmt_twos;
  logic [NUM_CH-1:0] invert,        next_invert;
  logic              out_disable,   next_out_disable;
  logic [1:0]        edge_f,        next_edge_f;
  logic [1:0]        drive_f,       next_drive_f;
  logic              ref_ext,       next_ref_ext;
  logic [1:0]        ref_lvl,       next_ref_lvl;
  logic [7:0]        pat_low,       next_pat_low;
  logic [7:0]        pat_high,      next_pat_high;
  logic [7:0]        rd_data;
  logic [6:0]        hdr_addr;
  logic [15:0]       frame;
  always_comb begin
    hdr_addr = rx_shift[6:0];
    rd_data  = 8'h00;
    case (hdr_addr)
      aor_pkg::ADDR_PREAMP_BIAS_LEVEL:     rd_data = aor_pkg::BIAS_FIXED_BITS | {6'h00, bias};
      aor_pkg::ADDR_OUTPUT_FORMAT_CONTROL: rd_data = {5'h00, invert[chan_sel], 1'b0, fmt_twos};
      aor_pkg::ADDR_OUTPUT_DRIVE_ADJUST:   rd_data = {out_disable, 3'h0, edge_f, drive_f};
      aor_pkg::ADDR_REFERENCE_SELECT:      rd_data = {1'b0, ref_ext, 4'h0, ref_lvl};
      aor_pkg::ADDR_USER_PATTERN_ONE_LOW:  rd_data = pat_low;
      aor_pkg::ADDR_USER_PATTERN_ONE_HIGH: rd_data = pat_high;
      default:                             rd_data = 8'h00;
    endcase
  end
  always_comb begin
    next_bit_cnt     = bit_cnt;
    next_rx_shift    = rx_shift;
    next_tx_shift    = tx_shift;
    next_sdo         = sdo;
    next_sdo_oe_n    = sdo_oe_n;
    next_bias        = bias;
    next_fmt_twos    = fmt_twos;
    next_invert      = invert;
    next_out_disable = out_disable;
    next_edge_f      = edge_f;
    next_drive_f     = drive_f;
    next_ref_ext     = ref_ext;
    next_ref_lvl     = ref_lvl;
    next_pat_low     = pat_low;
    next_pat_high    = pat_high;
    frame            = {rx_shift[14:0], sdi_q[1]};
    if (!cs_active) begin
      // a frame cut short is simply dropped
      next_bit_cnt  = 5'h00;
      next_sdo_oe_n = 1'b1;
    end else if (sclk_rise && bit_cnt != aor_pkg::CNT_FRAME) begin
      next_rx_shift = frame;
      next_bit_cnt  = bit_cnt + 5'h01;
      if (bit_cnt == aor_pkg::CNT_HEADER - 5'h01 && frame[7]) begin
        next_tx_shift = 8'h00;
      end
      if (bit_cnt == aor_pkg::CNT_FRAME - 5'h01 && !rx_shift[14]) begin
        case (rx_shift[13:7])
          aor_pkg::ADDR_PREAMP_BIAS_LEVEL: begin
            next_bias = frame[aor_pkg::BIAS_LSB +: 2];
          end
          aor_pkg::ADDR_OUTPUT_FORMAT_CONTROL: begin
            next_fmt_twos = frame[aor_pkg::FMT_TWOS_BIT];
            next_invert[chan_sel] = frame[aor_pkg::FMT_INVERT_BIT];
          end
          aor_pkg::ADDR_OUTPUT_DRIVE_ADJUST: begin
            next_out_disable = frame[aor_pkg::ADJ_DISABLE_BIT];
            next_edge_f      = frame[aor_pkg::ADJ_EDGE_LSB +: 2];
            next_drive_f     = frame[aor_pkg::ADJ_DRIVE_LSB +: 2];
          end
          aor_pkg::ADDR_REFERENCE_SELECT: begin
            next_ref_ext = frame[aor_pkg::REF_EXTERNAL_BIT];
            next_ref_lvl = frame[aor_pkg::REF_LEVEL_LSB +: 2];
          end
          aor_pkg::ADDR_USER_PATTERN_ONE_LOW:  next_pat_low  = frame[7:0];
          aor_pkg::ADDR_USER_PATTERN_ONE_HIGH: next_pat_high = frame[7:0];
          default: next_pat_low = pat_low;
        endcase
      end
    end else if (sclk_fall && rx_shift[7] && bit_cnt == aor_pkg::CNT_HEADER) begin
      // header complete: load read data and drive its msb
      next_sdo      = rd_data[7];
      next_tx_shift = {rd_data[6:0], 1'b0};
      next_sdo_oe_n = 1'b0;
    end else if (sclk_fall && !sdo_oe_n && bit_cnt > aor_pkg::CNT_HEADER) begin
      next_sdo      = tx_shift[7];
      next_tx_shift = {tx_shift[6:0], 1'b0};
      if (bit_cnt == aor_pkg::CNT_FRAME) begin
        next_sdo_oe_n = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit_cnt     <= 5'h00;
      rx_shift    <= 16'h0000;
      tx_shift    <= 8'h00;
      sdo         <= 1'b0;
      sdo_oe_n    <= 1'b1;
      bias        <= aor_pkg::RST_PREAMP_BIAS_LEVEL[1:0];
      fmt_twos    <= aor_pkg::RST_OUTPUT_FORMAT_CONTROL[aor_pkg::FMT_TWOS_BIT];
      invert      <= '0;
      out_disable <= aor_pkg::RST_OUTPUT_DRIVE_ADJUST[aor_pkg::ADJ_DISABLE_BIT];
      edge_f      <= aor_pkg::RST_OUTPUT_DRIVE_ADJUST[aor_pkg::ADJ_EDGE_LSB +: 2];
      drive_f     <= aor_pkg::RST_OUTPUT_DRIVE_ADJUST[aor_pkg::ADJ_DRIVE_LSB +: 2];
      ref_ext     <= aor_pkg::RST_REFERENCE_SELECT[aor_pkg::REF_EXTERNAL_BIT];
      ref_lvl     <= aor_pkg::RST_REFERENCE_SELECT[aor_pkg::REF_LEVEL_LSB +: 2];
      pat_low     <= aor_pkg::RST_USER_PATTERN;
      pat_high    <= aor_pkg::RST_USER_PATTERN;
    end else begin
      bit_cnt     <= next_bit_cnt;
      rx_shift    <= next_rx_shift;
      tx_shift    <= next_tx_shift;
      sdo         <= next_sdo;
      sdo_oe_n    <= next_sdo_oe_n;
      bias        <= next_bias;
      fmt_twos    <= next_fmt_twos;
      invert      <= next_invert;
      out_disable <= next_out_disable;
      edge_f      <= next_edge_f;
      drive_f     <= next_drive_f;
      ref_ext     <= next_ref_ext;
      ref_lvl     <= next_ref_lvl;
      pat_low     <= next_pat_low;
      pat_high    <= next_pat_high;
    end
  end
  assign spi_sdio_out   = sdo;
  assign spi_sdio_oe_n  = sdo_oe_n;
  assign preamp_bias    = bias;
  assign edge_rate      = edge_f;
  assign drive_strength = drive_f;
  assign ref_external   = ref_ext;
  assign ref_level      = ref_lvl;
  // ---------------------------------------------------------------
  // output data path
  // ---------------------------------------------------------------
  logic        dv_q,  next_dv;
  logic [2:0]  ch_q,  next_ch;
  logic [11:0] dat_q, next_dat;
  logic        oe_q,  next_oe;
  logic [11:0]             word;
  logic                    fmt_applies;
  aor_pkg::aor_test_mode_t tmode;
  always_comb begin
    tmode = aor_pkg::aor_test_mode_t'(test_pattern_control);
    word  = adc_data;
    // pn modes need a generator that lives elsewhere; live data passes
    case (tmode)
      aor_pkg::AOR_TM_MID:      word = aor_pkg::PAT_MID;
      aor_pkg::AOR_TM_PFS:      word = aor_pkg::PAT_PFS;
      aor_pkg::AOR_TM_NFS:      word = aor_pkg::PAT_NFS;
      aor_pkg::AOR_TM_CHECKER:  word = aor_pkg::PAT_CHECKER;
      aor_pkg::AOR_TM_WORD_TGL: word = aor_pkg::PAT_PFS;
      aor_pkg::AOR_TM_USER:     word = {pat_high, pat_low[7:4]};
      aor_pkg::AOR_TM_BIT_TGL:  word = aor_pkg::PAT_CHECKER;
      aor_pkg::AOR_TM_SYNC:     word = aor_pkg::PAT_SYNC;
      aor_pkg::AOR_TM_ONE_HIGH: word = aor_pkg::PAT_MID;
      aor_pkg::AOR_TM_MIXED:    word = aor_pkg::PAT_MIXED;
      default:                  word = adc_data;
    endcase
    // fixed bit patterns ignore the format bit
    fmt_applies = !(tmode inside {aor_pkg::AOR_TM_CHECKER, aor_pkg::AOR_TM_WORD_TGL, aor_pkg::AOR_TM_USER,
                                  aor_pkg::AOR_TM_BIT_TGL, aor_pkg::AOR_TM_SYNC, aor_pkg::AOR_TM_ONE_HIGH,
                                  aor_pkg::AOR_TM_MIXED});
    next_dv  = adc_valid;
    next_ch  = adc_ch;
    next_dat = dat_q;
    if (adc_valid) begin
      next_dat = word;
      if (fmt_applies && fmt_twos) begin
        next_dat[11] = ~word[11];
      end
      if (adc_ch < 3'(NUM_CH) && invert[adc_ch]) begin
        next_dat = ~next_dat;
      end
    end
    next_oe = out_disable;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dv_q  <= 1'b0;
      ch_q  <= 3'h0;
      dat_q <= 12'h000;
      oe_q  <= 1'b0;
    end else begin
      dv_q  <= next_dv;
      ch_q  <= next_ch;
      dat_q <= next_dat;
      oe_q  <= next_oe;
    end
  end
  assign data_valid = dv_q;
  assign data_ch    = ch_q;
  assign data_out   = dat_q;
  assign data_oe_n  = oe_q;
endmodule

// [verif/aor_output_config_regs_properties.sv]
// concurrent checks on the output configuration register slice ports
`timescale 1ns/1ps
module aor_regs_checker (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        spi_csb_n,
  input wire logic        spi_sdio_oe_n,
  input wire logic [3:0]  test_pattern_control,
  input wire logic        adc_valid,
  input wire logic [2:0]  adc_ch,
  input wire logic [11:0] adc_data,
  input wire logic        data_valid,
  input wire logic [2:0]  data_ch,
  input wire logic [11:0] data_out,
  input wire logic        data_oe_n,
  input wire logic [1:0]  preamp_bias,
  input wire logic [1:0]  edge_rate,
  input wire logic [1:0]  drive_strength,
  input wire logic        ref_external,
  input wire logic [1:0]  ref_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // six idle cycles clear the two-flop select synchroniser and the commit stage
  sequence s_idle;
    spi_csb_n [*6];
  endsequence
  sequence s_live;
    adc_valid && test_pattern_control == 4'h0;
  endsequence
  // three deselected cycles cover the select synchroniser
  sequence s_deselect;
    spi_csb_n [*3];
  endsequence
  a_valid_next: assert property (adc_valid |=> data_valid && data_ch == $past(adc_ch))
    else $error("sample not passed on next cycle");
  a_hold_idle: assert property (!adc_valid |=> !data_valid && $stable(data_out))
    else $error("output word moved without a sample");
  a_live_format: assert property (s_live |=>
    (data_out[10:0] ^ $past(adc_data[10:0])) inside {11'h000, 11'h7ff})
    else $error("live word altered beyond format and invert");
  a_toggle_word: assert property (adc_valid && test_pattern_control == 4'h9
    |=> data_out inside {12'haaa, 12'h555})
    else $error("bit toggle word wrong");
  a_sync_word: assert property (adc_valid && test_pattern_control == 4'ha
    |=> data_out inside {12'h03f, 12'hfc0})
    else $error("sync word wrong");
  a_adjust_reset: assert property ($fell(reset) |->
    !data_oe_n && edge_rate == 2'h3 && drive_strength == 2'h3)
    else $error("drive adjust fields not at reset value");
  a_ref_reset: assert property ($fell(reset) |->
    !ref_external && ref_level == 2'h3 && preamp_bias == 2'h1)
    else $error("reference or bias not at reset value");
  a_cfg_still: assert property (s_idle |=> $stable({data_oe_n, edge_rate, drive_strength, ref_external,
    ref_level, preamp_bias}))
    else $error("field changed with no frame");
  a_sdo_release: assert property (s_deselect |=> spi_sdio_oe_n)
    else $error("serial data still driven while deselected");
endmodule
bind aor_output_config_regs aor_regs_checker chk_u (.clk_sys, .reset, .spi_csb_n, .spi_sdio_oe_n, .test_pattern_control,
  .adc_valid, .adc_ch, .adc_data, .data_valid, .data_ch, .data_out, .data_oe_n, .preamp_bias, .edge_rate,
  .drive_strength, .ref_external, .ref_level);

// [verif/aor_spi_host.sv]
// serial configuration host model issuing 16-bit frames
`timescale 1ns/1ps
module aor_spi_host (
  input  wire logic clk_sys,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdi
);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdi = 1'b0;
  end
  // hp is the half period in clk cycles, at least 4
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd, input int hp,
                      output logic [7:0] rd);
    logic [15:0] f;
    f = {rw, a, wd};
    rd = 8'h00;
    csb_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = (rw && i < 8) ? ~sdi : f[i];
      repeat (hp) @(negedge clk_sys);
      // a released line reads inverted, so a late enable shows up
      rd[i%8] = sdo_oe_n ? ~sdo : sdo;
      sclk = 1'b1;
      repeat (hp) @(negedge clk_sys);
      sclk = 1'b0;
    end
    repeat (hp) @(negedge clk_sys);
    csb_n = 1'b1;
    sdi = ~sdi;
    repeat (hp) @(negedge clk_sys);
  endtask
endmodule

// [verif/aor_output_config_regs_tb_top.sv]
// self-checking bench for the output configuration register slice
`timescale 1ns/1ps
`define CHK(w, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", w, e, g); end end
module aor_output_config_regs_tb_top;
  localparam logic [6:0] ADR [7] = '{7'h12, 7'h14, 7'h15, 7'h18, 7'h19, 7'h1a, 7'h13};
  localparam logic [7:0] RST [7] = '{8'h09, 8'h00, 8'h0f, 8'h03, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [7] = '{8'h03, 8'h05, 8'h8f, 8'h43, 8'hff, 8'hff, 8'h00};
  localparam logic [3:0] MODE [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        sclk, csb_n, sdi, sdo, sdo_oe_n, data_valid, data_oe_n, ref_external;
  logic [2:0]  chan_sel = 3'h0;
  logic [2:0]  adc_ch = 3'h0;
  logic [2:0]  data_ch;
  logic [3:0]  tpc = 4'h0;
  logic        adc_valid = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [11:0] data_out;
  logic [1:0]  preamp_bias, edge_rate, drive_strength, ref_level;
  logic [7:0]  rd, w [7];
  logic [4:0]  inv = 5'h00;
  logic        twos = 1'b0;
  logic [14:0] q [$];
  logic [14:0] mexp;
  int          err_count = 0;
  int          tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  aor_spi_host host_u (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk), .csb_n(csb_n), .sdi(sdi));
  aor_output_config_regs dut_u (.clk_sys, .reset, .spi_sclk(sclk), .spi_csb_n(csb_n), .spi_sdio_in(sdi),
    .spi_sdio_out(sdo), .spi_sdio_oe_n(sdo_oe_n), .chan_sel, .test_pattern_control(tpc), .adc_valid, .adc_ch,
    .adc_data, .data_valid, .data_ch, .data_out, .data_oe_n, .preamp_bias, .edge_rate, .drive_strength,
    .ref_external, .ref_level);
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, 6, rd);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e, input int hp);
    host_u.xfer(1'b1, a, 8'h00, hp, rd);
    `CHK("register", e, rd)
  endtask
  function automatic logic [11:0] expect_word(input logic [3:0] m, input logic [11:0] d, input logic [2:0] c);
    logic [11:0] x;
    case (m)
      4'h1: x = 12'h800;
      4'h2: x = 12'hfff;
      4'h3: x = 12'h000;
      4'h4: x = 12'haaa;
      4'h7: x = 12'hfff;
      4'h8: x = {w[5], w[4][7:4]};
      4'h9: x = 12'haaa;
      4'ha: x = 12'h03f;
      4'hb: x = 12'h800;
      4'hc: x = 12'ha33;
      default: x = d;
    endcase
    // format only touches live data, pn and the three fixed-level words
    if (twos && (m < 4'h4 || m == 4'h5 || m == 4'h6)) x[11] = ~x[11];
    return inv[c] ? ~x : x;
  endfunction
  task automatic burst(input logic [3:0] m);
    for (int k = 0; k < 8; k++) begin
      adc_valid = ($urandom_range(3) != 0);
      adc_ch = 3'($urandom_range(4));
      adc_data = 12'($urandom);
      tpc = m;
      if (adc_valid) q.push_back({adc_ch, expect_word(m, adc_data, adc_ch)});
      @(negedge clk_sys);
    end
    adc_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    #1;
    if (data_valid === 1'b1) begin
      mexp = (q.size() > 0) ? q.pop_front() : 15'h7fff;
      `CHK("data word", mexp, {data_ch, data_out})
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(78));
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 7; i++) rchk(ADR[i], RST[i], 6 + 2 * i);
    for (int i = 0; i < 7; i++) begin
      w[i] = 8'($urandom);
      wr(ADR[i], w[i]);
      rchk(ADR[i], (w[i] & MSK[i]) | (i == 0 ? 8'h08 : 8'h00), 6);
    end
    `CHK("adjust", {w[2][7], w[2][3:0]}, {data_oe_n, edge_rate, drive_strength})
    `CHK("ref", {w[3][6], w[3][1:0], w[0][1:0]}, {ref_external, ref_level, preamp_bias})
    for (int b = 1; b >= 0; b--) begin
      wr(7'h15, {b[0], 7'h0c});
      `CHK("oe", b[0], data_oe_n)
    end
    for (int t = 0; t < 2; t++) begin
      twos = t[0];
      for (int c = 0; c < 5; c++) begin
        chan_sel = 3'(c);
        inv[c] = 1'($urandom);
        wr(7'h14, {5'h00, inv[c], 1'b0, twos});
        rchk(7'h14, {5'h00, inv[c], 1'b0, twos}, 6);
      end
      foreach (MODE[m]) burst(MODE[m]);
    end
    `CHK("drained", 0, q.size())
    stop_test();
  end
endmodule
